// ===== verilog/expander_params.svh
`ifndef EXPANDER_PARAMS_SVH
`define EXPANDER_PARAMS_SVH
`define CLK_PERIOD_NS      10
`define ALERT_VALID_NS     4000
`define ALERT_CLEAR_NS     4000
`define ADDR_PREFIX        4'h7
`define REG_SEL_INPUT      2'h0
`define REG_SEL_OUTPUT     2'h1
`define REG_SEL_POLARITY   2'h2
`define REG_SEL_DIRECTION  2'h3
`define RST_OUTPUT         8'hFF
`define RST_POLARITY       8'h00
`define RST_DIRECTION      8'hFF
`define BITS_PER_BYTE      4'h8
`endif

// ===== verilog/expander_pkg.sv
package expander_pkg;
   typedef enum logic [2:0] {
      IDLE,
      ADDR,
      ADDR_ACK,
      WR_BYTE,
      WR_ACK,
      RD_BYTE,
      RD_ACK
   } bus_state_t;

   typedef struct packed {
      logic [7:0] output_latch;
      logic [7:0] polarity;
      logic [7:0] direction;
   } port_regs_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } serial_t;
endpackage

// ===== verilog/i2c_port_expander_core.sv
`timescale 1ns/10ps
`include "expander_params.svh"
// Overview of operation
// RL1: Interrupt output goes valid within 4 us of a qualifying input pin change.
// RL2: Interrupt output releases within 4 us of the clearing serial clock edge.
// RL3: Interrupt asserted while any input pin differs from captured input register.
// RL4: Both rising and falling edges on input pins cause interrupts.
// RL5: Interrupt clears when pins return to captured levels or input register read.
// RL6: Input register read clears interrupt at acknowledge bit, after rising clock edge.
// RL7: After clearing, every further input change is detected and signalled again.
// RL8: Foreign bus traffic leaves interrupt unaffected; output pins never interrupt.
// RL9: Switching a pin to input may interrupt if level mismatches stored bit.
// RL10: Interrupt output only drives low or releases; pull-up provides high.
// RL11: Input pins have both drivers off, high impedance with weak pull-up.
// RL12: Output pins drive high or low per output register bit.
// RL13: Reset loads register defaults, initialises bus machine; all pins start inputs.
// RL14: Polarity register applies to input readback; every register is readable.
// RL15: Slave address includes three strap inputs, allowing eight devices per bus.
// RL16: System keeps strap inputs constant between start and stop conditions.
// RL17: Start is data falling while clock high; address follows MSB first, then R/W.
// RL18: Stop is data rising while clock high; device recognises it.
// RL19: Data changes only while clock low; changes during clock high are start/stop.
// RL20: Matching address is acknowledged by holding data low through ninth clock high.
// RL21: Each byte has an acknowledge bit; addressed receiver acknowledges every byte.
// RL22: Master NACK on last read byte makes device release data for stop.
// RL23: Address is 0111 plus three strap bits; eighth bit 1 reads, 0 writes.
// RL24: First written byte selects register: 0 input, 1 output, 2 polarity, 3 direction.
// RL25: No auto-increment; the last of several written bytes stays in the register.
// RL26: Output register read returns latch value, not pin level.
// RL27: Selected register remains the read target until a new select byte.
// RL28: Reset values: output all ones, polarity all zeros, direction all ones.
// RL29: Direction one means input, zero output; polarity one inverts input readback.
module i2c_port_expander_core
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             i_clock,
   input  wire logic             i_rst_b,
   input  wire logic             i_scl,
   input  wire logic             i_sda,
   output logic                  o_sda,
   output logic                  o_sda_oe,
   input  wire logic             i_addr_strap_0,
   input  wire logic             i_addr_strap_1,
   input  wire logic             i_addr_strap_2,
   input  wire logic [WIDTH-1:0] i_expander_pins,
   output logic      [WIDTH-1:0] o_expander_pins,
   output logic      [WIDTH-1:0] o_expander_pins_oe,
   output logic                  o_alert,
   output logic                  o_alert_oe
);
   import expander_pkg::*;

   // Two-flop synchronisers; the first stage feeds only the second.
   serial_t          ser_meta;
   serial_t          ser_sync;
   serial_t          ser_prev;
   logic [WIDTH-1:0] pin_meta;
   logic [WIDTH-1:0] pin_sync;
   logic [2:0]       strap_meta;
   logic [2:0]       strap_sync;

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ser_meta   <= '1;
         ser_sync   <= '1;
         ser_prev   <= '1;
         pin_meta   <= '1;
         pin_sync   <= '1;
         strap_meta <= '0;
         strap_sync <= '0;
      end
      else
      begin
         ser_meta   <= '{scl: i_scl, sda: i_sda};
         ser_sync   <= ser_meta;
         ser_prev   <= ser_sync;
         pin_meta   <= i_expander_pins;
         pin_sync   <= pin_meta;
         strap_meta <= {i_addr_strap_2, i_addr_strap_1, i_addr_strap_0};
         strap_sync <= strap_meta;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   assign scl_rise  = ser_sync.scl & ~ser_prev.scl;
   assign scl_fall  = ~ser_sync.scl & ser_prev.scl;
   assign start_det = ser_sync.scl & ser_prev.scl & ser_prev.sda & ~ser_sync.sda; // [RL17] [RL19]
   assign stop_det  = ser_sync.scl & ser_prev.scl & ~ser_prev.sda & ser_sync.sda; // [RL18] [RL19]

   // Readback of the selected register.
   function automatic logic [7:0] reg_read(input logic [1:0] sel, input port_regs_t r,
                                           input logic [WIDTH-1:0] in_reg);
      unique case (sel)
         `REG_SEL_INPUT:    reg_read = in_reg ^ r.polarity; // [RL14] [RL29]
         `REG_SEL_OUTPUT:   reg_read = r.output_latch;      // [RL26]
         `REG_SEL_POLARITY: reg_read = r.polarity;
         `REG_SEL_DIRECTION:reg_read = r.direction;
      endcase
   endfunction

   bus_state_t       state;
   bus_state_t       next_state;
   logic [3:0]       bit_cnt;
   logic [3:0]       next_bit_cnt;
   logic [7:0]       shift;
   logic [7:0]       next_shift;
   logic             have_sel;
   logic             next_have_sel;
   logic [1:0]       sel;
   logic [1:0]       next_sel;
   port_regs_t       regs;
   port_regs_t       next_regs;
   logic [WIDTH-1:0] in_reg;
   logic [WIDTH-1:0] next_in_reg;
   logic             sda_low;
   logic             next_sda_low;
   logic             clear_pulse;
   logic [7:0]       read_val;

   always_comb
   begin
      read_val      = reg_read(sel, regs, in_reg);
      next_state    = state;
      next_bit_cnt  = bit_cnt;
      next_shift    = shift;
      next_have_sel = have_sel;
      next_sel      = sel;
      next_regs     = regs;
      next_sda_low  = sda_low;
      clear_pulse   = 1'b0;
      // The input register is recaptured only at an input-register read, so the alert compares against it.
      next_in_reg   = in_reg;
      if (start_det)
      begin
         next_state   = ADDR;
         next_bit_cnt = '0;
         next_sda_low = 1'b0;
      end
      else if (stop_det)
      begin
         next_state   = IDLE;
         next_sda_low = 1'b0;
      end
      else
      begin
         unique case (state)
            IDLE:
            begin
               next_sda_low = 1'b0;
            end
            ADDR, WR_BYTE:
            begin
               if (scl_rise)
               begin
                  next_shift   = {shift[6:0], ser_sync.sda}; // [RL17]
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               else if (scl_fall && bit_cnt == `BITS_PER_BYTE)
               begin
                  next_bit_cnt = '0;
                  if (state == ADDR)
                  begin
                     if (shift[7:1] == {`ADDR_PREFIX, strap_sync}) // [RL15] [RL23]
                     begin
                        next_state   = ADDR_ACK;
                        next_sda_low = 1'b1; // [RL20]
                     end
                     else
                        next_state = IDLE; // [RL8]
                  end
                  else
                  begin
                     next_state   = WR_ACK;
                     next_sda_low = 1'b1; // [RL21]
                     if (!have_sel)
                     begin
                        next_sel      = shift[1:0]; // [RL24] [RL27]
                        next_have_sel = 1'b1;
                     end
                     else
                     begin
                        unique case (sel) // [RL25]
                           `REG_SEL_INPUT:     ;
                           `REG_SEL_OUTPUT:    next_regs.output_latch = shift;
                           `REG_SEL_POLARITY:  next_regs.polarity     = shift;
                           `REG_SEL_DIRECTION: next_regs.direction    = shift;
                        endcase
                     end
                  end
               end
            end
            ADDR_ACK, WR_ACK:
            begin
               if (scl_rise && state == ADDR_ACK && shift[0] && sel == `REG_SEL_INPUT)
                  clear_pulse = 1'b1; // [RL6]
               if (scl_fall)
               begin
                  if (state == ADDR_ACK && shift[0])
                  begin
                     next_state   = RD_BYTE;
                     next_shift   = read_val;
                     next_sda_low = ~read_val[7];
                     next_bit_cnt = 4'h1;
                  end
                  else
                  begin
                     next_state    = WR_BYTE;
                     next_sda_low  = 1'b0;
                     if (state == ADDR_ACK)
                        next_have_sel = 1'b0;
                  end
               end
            end
            RD_BYTE:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt == `BITS_PER_BYTE)
                  begin
                     next_state   = RD_ACK;
                     next_sda_low = 1'b0; // [RL21]
                  end
                  else
                  begin
                     next_sda_low = ~shift[7 - bit_cnt[2:0]];
                     next_bit_cnt = bit_cnt + 4'h1;
                  end
               end
            end
            RD_ACK:
            begin
               if (scl_rise)
               begin
                  if (ser_sync.sda)
                     next_state = IDLE; // [RL22]
                  else if (sel == `REG_SEL_INPUT)
                     clear_pulse = 1'b1; // [RL6]
               end
               else if (scl_fall)
               begin
                  next_state   = RD_BYTE;
                  next_shift   = read_val;
                  next_sda_low = ~read_val[7];
                  next_bit_cnt = 4'h1;
               end
            end
         endcase
      end
      // Capture on clear; a change racing the ack edge may be swallowed here.
      if (clear_pulse)
         next_in_reg = pin_sync; // [RL5] [RL6] [RL7]
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state    <= IDLE; // [RL13]
         bit_cnt  <= '0;
         shift    <= '0;
         have_sel <= 1'b0;
         sel      <= `REG_SEL_INPUT;
         regs     <= '{output_latch: `RST_OUTPUT, polarity: `RST_POLARITY, direction: `RST_DIRECTION}; // [RL28]
         in_reg   <= '1;
         sda_low  <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         bit_cnt  <= next_bit_cnt;
         shift    <= next_shift;
         have_sel <= next_have_sel;
         sel      <= next_sel;
         regs     <= next_regs;
         in_reg   <= next_in_reg;
         sda_low  <= next_sda_low;
      end
   end

   // Mismatch is evaluated on input pins only; sync latency is far inside the bound.
   logic             mismatch;
   logic             alert_low;
   logic             next_alert_low;
   logic [WIDTH-1:0] pin_out;
   logic [WIDTH-1:0] pin_oe;
   logic [WIDTH-1:0] next_pin_out;
   logic [WIDTH-1:0] next_pin_oe;

   always_comb
   begin
      mismatch = |((pin_sync ^ in_reg) & regs.direction); // [RL3] [RL4] [RL8] [RL9]
      next_alert_low = mismatch & ~clear_pulse; // [RL1] [RL2] [RL5] [RL7]
      next_pin_oe    = ~regs.direction;          // [RL11] [RL12] [RL29]
      next_pin_out   = regs.output_latch & ~regs.direction; // [RL12]
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         alert_low <= 1'b0;
         pin_out   <= '0;
         pin_oe    <= '0; // [RL13]
      end
      else
      begin
         alert_low <= next_alert_low;
         pin_out   <= next_pin_out;
         pin_oe    <= next_pin_oe;
      end
   end

   assign o_sda              = 1'b0;
   assign o_sda_oe           = sda_low;
   assign o_alert            = 1'b0; // [RL10]
   assign o_alert_oe         = alert_low;
   assign o_expander_pins    = pin_out;
   assign o_expander_pins_oe = pin_oe;
endmodule

// ===== verification/expander_chk.sv
`timescale 1ns/10ps
module expander_chk
#(
   parameter int WIDTH = 8
)
(
   input wire logic             i_clock,
   input wire logic             i_rst_b,
   input wire logic             i_scl,
   input wire logic             o_sda,
   input wire logic             o_sda_oe,
   input wire logic [WIDTH-1:0] i_expander_pins,
   input wire logic [WIDTH-1:0] o_expander_pins,
   input wire logic [WIDTH-1:0] o_expander_pins_oe,
   input wire logic             o_alert,
   input wire logic             o_alert_oe
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   sequence s_input_change;
      !o_alert_oe && $stable(o_expander_pins_oe)
      && |((i_expander_pins ^ $past(i_expander_pins)) & ~o_expander_pins_oe);
   endsequence
   // Six quiet cycles cover the synchroniser, so a late alert cannot hide here.
   sequence s_inputs_quiet;
      (!o_alert_oe && $stable(o_expander_pins_oe) && $stable(i_expander_pins & ~o_expander_pins_oe)) [*6];
   endsequence
   sequence s_low_held;
      o_sda_oe [*6];
   endsequence
   a_alert_valid_delay: assert property (s_input_change |=> ##[0:399] o_alert_oe)
      else $error("alert late after input change");
   a_output_no_alert: assert property (s_inputs_quiet |=> !o_alert_oe)
      else $error("alert without input change");
   a_alert_open_drain: assert property (o_alert == 1'b0 && o_sda == 1'b0)
      else $error("open drain value not low");
   a_input_released: assert property ((o_expander_pins & ~o_expander_pins_oe) == '0)
      else $error("input pin has drive value");
   a_pins_on_low: assert property ($changed(o_expander_pins_oe) || $changed(o_expander_pins) |-> !i_scl)
      else $error("pin drive changed while clock high");
   a_reset_inputs: assert property ($rose(i_rst_b) |-> o_expander_pins_oe == '0 && !o_alert_oe)
      else $error("pins or alert active after reset");
   a_sda_on_low: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("data changed while clock high");
   a_ack_held_high: assert property ($rose(i_scl) && o_sda_oe |-> s_low_held)
      else $error("data low not held in clock high");
endmodule
bind i2c_port_expander_core expander_chk #(.WIDTH(WIDTH)) chk (.i_clock(i_clock), .i_rst_b(i_rst_b),
   .i_scl(i_scl), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_expander_pins(i_expander_pins),
   .o_expander_pins(o_expander_pins), .o_expander_pins_oe(o_expander_pins_oe), .o_alert(o_alert),
   .o_alert_oe(o_alert_oe));

// ===== verification/i2c_host_model.sv
`timescale 1ns/10ps
module i2c_host_model
(
   input  wire logic i_clock,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic wait_cycles(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   task automatic start();
      wait_cycles(1);
      o_sda_low <= 1'b0;
      wait_cycles(8);
      o_scl <= 1'b1;
      wait_cycles(8);
      o_sda_low <= 1'b1;
      wait_cycles(8);
      o_scl <= 1'b0;
   endtask
   task automatic stop();
      wait_cycles(1);
      o_sda_low <= 1'b1;
      wait_cycles(7);
      o_scl <= 1'b1;
      wait_cycles(8);
      o_sda_low <= 1'b0;
      wait_cycles(8);
   endtask
   // One cycle after the clock falls, so data never moves with the clock edge.
   task automatic put_bit(input logic b, output logic r);
      wait_cycles(1);
      o_sda_low <= !b;
      wait_cycles(7);
      o_scl <= 1'b1;
      wait_cycles(8);
      r = i_sda;
      o_scl <= 1'b0;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(d[i], r);
      put_bit(1'b1, r);
      ack = !r;
   endtask
   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         put_bit(1'b1, r);
         d[i] = r;
      end
      put_bit(last, r);
   endtask
endmodule

// ===== verification/tb_i2c_port_expander_core.sv
`timescale 1ns/10ps
`include "expander_params.svh"
module tb_i2c_port_expander_core;
   import expander_pkg::*;
   logic       clock;
   logic       rst_b;
   logic [2:0] strap;
   logic [7:0] ext_pins;
   logic [7:0] pin_out;
   logic [7:0] pin_oe;
   logic [7:0] pin_line;
   logic       sda_oe;
   logic       alert_oe;
   logic       scl;
   logic       host_low;
   logic       sda_line;
   int         num_errors = 0;
   int         samples_checked = 0;
   assign sda_line = ~(host_low | sda_oe);
   assign pin_line = (pin_oe & pin_out) | (~pin_oe & ext_pins);
   i2c_host_model host (.i_clock(clock), .i_sda(sda_line), .o_scl(scl), .o_sda_low(host_low));
   i2c_port_expander_core #(.WIDTH(8)) dut (.i_clock(clock), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda_line),
      .o_sda(), .o_sda_oe(sda_oe), .i_addr_strap_0(strap[0]), .i_addr_strap_1(strap[1]),
      .i_addr_strap_2(strap[2]), .i_expander_pins(pin_line), .o_expander_pins(pin_out),
      .o_expander_pins_oe(pin_oe), .o_alert(), .o_alert_oe(alert_oe));
   task automatic tally_and_finish();
      if (num_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic check_alert(input logic want);
      check("alert", {7'h00, alert_oe}, {7'h00, want});
   endtask
   task automatic wait_alert(input logic want);
      int n;
      n = 0;
      while (alert_oe !== want && n < `ALERT_VALID_NS / `CLK_PERIOD_NS)
      begin
         @(posedge clock);
         n++;
      end
      check_alert(want);
      if (alert_oe !== want) tally_and_finish();
   endtask
   task automatic wr(input logic [1:0] sel, input logic [7:0] d);
      logic a;
      host.start();
      host.send({`ADDR_PREFIX, strap, 1'b0}, a);
      check("addr ack", {7'h00, a}, 8'h01);
      host.send({6'h00, sel}, a);
      host.send(d, a);
      check("data ack", {7'h00, a}, 8'h01);
      host.stop();
   endtask
   task automatic rd(input logic [1:0] sel, input logic [7:0] want, input string what);
      logic       a;
      logic [7:0] d;
      host.start();
      host.send({`ADDR_PREFIX, strap, 1'b0}, a);
      host.send({6'h00, sel}, a);
      host.start();
      host.send({`ADDR_PREFIX, strap, 1'b1}, a);
      host.recv(1'b0, d);
      check(what, d, want);
      host.recv(1'b1, d);
      check(what, d, want);
      host.stop();
   endtask
   task automatic t_reset();
      check("pin oe", pin_oe, 8'h00);
      check("pin drive", pin_out, 8'h00);
      check_alert(1'b0);
      rd(2'h1, 8'hFF, "output reg");
      rd(2'h2, 8'h00, "polarity reg");
      rd(2'h3, 8'hFF, "direction reg");
      rd(2'h0, 8'hFF, "input reg");
   endtask
   task automatic t_outputs();
      logic a;
      wr(2'h3, 8'h0F);
      host.start();
      host.send({`ADDR_PREFIX, strap, 1'b0}, a);
      host.send(8'h01, a);
      host.send(8'h00, a);
      host.send(8'h5A, a);
      host.stop();
      check("pin oe", pin_oe, 8'hF0);
      check("pin drive", pin_out, 8'h50);
      rd(2'h1, 8'h5A, "output reg");
      repeat (400) @(posedge clock);
      check_alert(1'b0);
   endtask
   task automatic t_alert();
      logic a;
      ext_pins[0] <= 1'b0;
      wait_alert(1'b1);
      ext_pins[0] <= 1'b1;
      wait_alert(1'b0);
      ext_pins[1] <= 1'b0;
      wait_alert(1'b1);
      host.start();
      host.send({`ADDR_PREFIX, ~strap, 1'b1}, a);
      check("foreign ack", {7'h00, a}, 8'h00);
      host.stop();
      check_alert(1'b1);
      rd(2'h0, 8'h5D, "input reg");
      check_alert(1'b0);
      ext_pins[1] <= 1'b1;
      wait_alert(1'b1);
      rd(2'h0, 8'h5F, "input reg");
      check_alert(1'b0);
   endtask
   task automatic t_polarity_and_turn();
      wr(2'h2, 8'h03);
      rd(2'h0, 8'h5C, "inverted input");
      rd(2'h2, 8'h03, "polarity reg");
      wr(2'h3, 8'h8F);
      wait_alert(1'b1);
      rd(2'h0, 8'hDC, "input reg");
      check_alert(1'b0);
      wr(2'h0, 8'h00);
      rd(2'h1, 8'h5A, "output reg");
   endtask
   // A reset in mid-run must undo every register write made so far.
   task automatic t_midrun_reset();
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      repeat (4) @(posedge clock);
      t_reset();
   endtask
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial
   begin
      rst_b = 1'b0;
      strap = 3'h5;
      ext_pins = 8'hFF;
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      repeat (4) @(posedge clock);
      t_reset();
      t_outputs();
      t_alert();
      t_polarity_and_turn();
      t_midrun_reset();
      tally_and_finish();
   end
endmodule
